// File: pmc_pkg.sv
package pmc_pkg;

   // global power modes, highest consumption first
   typedef enum logic [1:0] {
      MODE_ACTIVE,
      MODE_ALT_ACTIVE,
      MODE_SLEEP,
      MODE_HIBERNATE
   } power_mode_e;

   localparam int SUBSYS_W = 8;
   localparam int CORE_BIT = 0;
   localparam int FLASH_BIT = 1;

   // subsystems kept alive in sleep: bit positions of the sleep keep mask
   localparam logic [SUBSYS_W-1:0] SLEEP_KEEP_MASK = 8'h00;

   // wake sources, one bit each
   localparam int WAKE_W = 6;
   localparam int WAKE_PIN_BIT = 0;
   localparam int WAKE_CMP_BIT = 1;
   localparam int WAKE_SBUS_BIT = 2;
   localparam int WAKE_RTC_BIT = 3;
   localparam int WAKE_TIMEWHEEL_BIT = 4;
   localparam int WAKE_LVD_BIT = 5;

   localparam int CLK_MHZ = 200;
   localparam int SLEEP_RESUME_NS = 15000;
   localparam int HIB_RESUME_NS = 100000;
   // longest times round down
   localparam int SLEEP_RESUME_CYC = (SLEEP_RESUME_NS * CLK_MHZ) / 1000;
   localparam int HIB_RESUME_CYC = (HIB_RESUME_NS * CLK_MHZ) / 1000;
   localparam int CNT_W = 15;

   localparam logic [SUBSYS_W-1:0] ACT_TMPL_RST = 8'hFF;
   localparam logic [SUBSYS_W-1:0] ALT_TMPL_RST = 8'hFF;

   typedef struct packed {
      logic dig_reg_on;
      logic ana_reg_on;
      logic dig_reg_buzz;
      logic ana_reg_buzz;
      logic sleep_reg_on;
      logic hib_reg_on;
   } regulator_ctl_s;

   typedef struct packed {
      logic fast_clks_on;
      logic low_speed_clks_on;
      logic sleep_timer_on;
      logic rtc_on;
      logic retain;
   } clock_ctl_s;

endpackage : pmc_pkg

// File: power_mode_controller.sv
`timescale 1ns/100ps
// What this block does
// - four modes ranked: active, alternate active, sleep, hibernate
// - active mode powers each subsystem from its own active template bit, except the core, held on after a wakeup
// - active is the main state; any peripheral may be enabled by software
// - alternate active applies its own smaller template
// - alternate active may turn the core off while logic blocks run
// - sleep forces all subsystems off regardless of templates
// - sleep keeps sleep interval timer and real-time clock running
// - sleep puts digital and analog regulators into buzzed operation
// - hibernate stops all clocks but retains registers and ram
// - hibernate wakes only from a pin interrupt
// - hibernate disables all regulators except the hibernate regulator
// - hibernate retains configuration and memory contents
// - with external regulation, internal regulators may be off in non-hibernate modes
// - any wakeup returns to active and forces the core on
// - after reset the mode is active
// - sleep resume completes within 15 microseconds
// - hibernate resume completes within 100 microseconds
module power_mode_controller (
   // clock and reset
   input  wire logic                              i_sys_clk,
   input  wire logic                              i_sys_rst,
   // firmware control, same clock
   input  wire logic                              i_mode_wr,
   input  wire pmc_pkg::power_mode_e              i_mode_sel,
   input  wire logic [pmc_pkg::SUBSYS_W-1:0]      i_act_tmpl,
   input  wire logic [pmc_pkg::SUBSYS_W-1:0]      i_alt_tmpl,
   input  wire logic                              i_ext_reg,
   // wake sources, asynchronous
   input  wire logic [pmc_pkg::WAKE_W-1:0]        i_wake,
   input  wire logic [pmc_pkg::WAKE_W-1:0]        i_wake_en,
   // outputs
   output logic [pmc_pkg::SUBSYS_W-1:0]           o_subsys_en,
   output pmc_pkg::power_mode_e                   o_mode,
   output pmc_pkg::regulator_ctl_s                o_reg_ctl,
   output pmc_pkg::clock_ctl_s                    o_clk_ctl,
   output logic                                   o_resuming,
   output logic                                   o_wake_evt
);

   logic [pmc_pkg::WAKE_W-1:0] wake_meta_ff;
   logic [pmc_pkg::WAKE_W-1:0] wake_sync_ff;

   // two-flop synchroniser per wake line
   generate
      for (genvar g = 0; g < pmc_pkg::WAKE_W; g++) begin : g_sync
         always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               wake_meta_ff[g] <= 1'b0;
               wake_sync_ff[g] <= 1'b0;
            end else begin
               wake_meta_ff[g] <= i_wake[g];
               wake_sync_ff[g] <= wake_meta_ff[g];
            end
         end
      end
   endgenerate

   pmc_pkg::power_mode_e           mode_ff,     nxt_mode;
   logic                           resume_ff,   nxt_resume;
   logic [pmc_pkg::CNT_W-1:0]      cnt_ff,      nxt_cnt;
   logic                           core_force_ff, nxt_core_force;
   logic [pmc_pkg::SUBSYS_W-1:0]   subsys_ff,   nxt_subsys;
   pmc_pkg::regulator_ctl_s        reg_ff,      nxt_reg;
   pmc_pkg::clock_ctl_s            clk_ff,      nxt_clk;
   logic                           wake_evt_ff, nxt_wake_evt;
   logic                           wake_hit;
   logic [pmc_pkg::WAKE_W-1:0]     wake_act;

   localparam logic [pmc_pkg::CNT_W-1:0] SLEEP_CNT =
      pmc_pkg::CNT_W'(pmc_pkg::SLEEP_RESUME_CYC - 1);
   localparam logic [pmc_pkg::CNT_W-1:0] HIB_CNT =
      pmc_pkg::CNT_W'(pmc_pkg::HIB_RESUME_CYC - 1);

   // mode sequencing
   always_comb begin
      nxt_mode       = mode_ff;
      nxt_resume     = resume_ff;
      nxt_cnt        = cnt_ff;
      nxt_core_force = core_force_ff;
      nxt_wake_evt   = 1'b0;
      wake_act       = wake_sync_ff & i_wake_en;
      wake_hit       = 1'b0;
      case (mode_ff)
         pmc_pkg::MODE_HIBERNATE: begin
            wake_hit = wake_act[pmc_pkg::WAKE_PIN_BIT];
         end
         default: begin
            wake_hit = |wake_act;
         end
      endcase
      if (resume_ff) begin
         // regulators settle before active is declared
         if (cnt_ff == '0) begin
            nxt_resume = 1'b0;
            nxt_mode   = pmc_pkg::MODE_ACTIVE;
         end else begin
            nxt_cnt = cnt_ff - 1'b1;
         end
      end else if (wake_hit) begin
         nxt_wake_evt   = 1'b1;
         nxt_core_force = 1'b1;
         case (mode_ff)
            pmc_pkg::MODE_SLEEP: begin
               nxt_resume = 1'b1;
               nxt_cnt    = SLEEP_CNT;
            end
            pmc_pkg::MODE_HIBERNATE: begin
               nxt_resume = 1'b1;
               nxt_cnt    = HIB_CNT;
            end
            default: begin
               nxt_mode = pmc_pkg::MODE_ACTIVE;
            end
         endcase
      end else if (i_mode_wr) begin
         // only firmware writes move into low-power modes
         nxt_mode = i_mode_sel;
         if (i_mode_sel == pmc_pkg::MODE_ACTIVE) begin
            nxt_core_force = 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mode_ff       <= pmc_pkg::MODE_ACTIVE;
         resume_ff     <= 1'b0;
         cnt_ff        <= '0;
         core_force_ff <= 1'b0;
         wake_evt_ff   <= 1'b0;
      end else begin
         mode_ff       <= nxt_mode;
         resume_ff     <= nxt_resume;
         cnt_ff        <= nxt_cnt;
         core_force_ff <= nxt_core_force;
         wake_evt_ff   <= nxt_wake_evt;
      end
   end

   // power and clock gating from the next mode, so outputs follow at once
   always_comb begin
      nxt_subsys = '0;
      nxt_reg    = '0;
      nxt_clk    = '0;
      nxt_reg.sleep_reg_on = 1'b1;
      nxt_reg.hib_reg_on   = 1'b1;
      nxt_clk.retain       = 1'b1;
      if (nxt_resume) begin
         // resuming: regulators up, fabric held off until active
         nxt_reg.dig_reg_on = ~i_ext_reg;
         nxt_reg.ana_reg_on = ~i_ext_reg;
         nxt_clk.low_speed_clks_on = 1'b1;
      end else begin
         case (nxt_mode)
            pmc_pkg::MODE_ACTIVE: begin
               nxt_subsys = i_act_tmpl;
               nxt_reg.dig_reg_on = ~i_ext_reg;
               nxt_reg.ana_reg_on = ~i_ext_reg;
               nxt_clk.fast_clks_on      = 1'b1;
               nxt_clk.low_speed_clks_on = 1'b1;
               nxt_clk.sleep_timer_on    = 1'b1;
               nxt_clk.rtc_on            = 1'b1;
            end
            pmc_pkg::MODE_ALT_ACTIVE: begin
               // core bit may be clear while logic blocks keep running
               nxt_subsys = i_alt_tmpl;
               nxt_reg.dig_reg_on = ~i_ext_reg;
               nxt_reg.ana_reg_on = ~i_ext_reg;
               nxt_clk.fast_clks_on      = 1'b1;
               nxt_clk.low_speed_clks_on = 1'b1;
               nxt_clk.sleep_timer_on    = 1'b1;
               nxt_clk.rtc_on            = 1'b1;
            end
            pmc_pkg::MODE_SLEEP: begin
               nxt_subsys = pmc_pkg::SLEEP_KEEP_MASK;
               nxt_reg.dig_reg_on   = ~i_ext_reg;
               nxt_reg.ana_reg_on   = ~i_ext_reg;
               nxt_reg.dig_reg_buzz = ~i_ext_reg;
               nxt_reg.ana_reg_buzz = ~i_ext_reg;
               nxt_clk.low_speed_clks_on = 1'b1;
               nxt_clk.sleep_timer_on    = 1'b1;
               nxt_clk.rtc_on            = 1'b1;
            end
            default: begin
               // hibernate: everything off but the hibernate regulator and retain
               nxt_reg.sleep_reg_on = 1'b0;
               nxt_clk = '0;
               nxt_clk.retain = 1'b1;
            end
         endcase
         if (nxt_core_force && nxt_mode == pmc_pkg::MODE_ACTIVE) begin
            nxt_subsys[pmc_pkg::CORE_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         subsys_ff <= pmc_pkg::ACT_TMPL_RST;
         reg_ff    <= '{dig_reg_on: 1'b1, ana_reg_on: 1'b1, dig_reg_buzz: 1'b0,
                        ana_reg_buzz: 1'b0, sleep_reg_on: 1'b1, hib_reg_on: 1'b1};
         clk_ff    <= '{fast_clks_on: 1'b1, low_speed_clks_on: 1'b1,
                        sleep_timer_on: 1'b1, rtc_on: 1'b1, retain: 1'b1};
      end else begin
         subsys_ff <= nxt_subsys;
         reg_ff    <= nxt_reg;
         clk_ff    <= nxt_clk;
      end
   end

   assign o_mode      = mode_ff;
   assign o_subsys_en = subsys_ff;
   assign o_reg_ctl   = reg_ff;
   assign o_clk_ctl   = clk_ff;
   assign o_resuming  = resume_ff;
   assign o_wake_evt  = wake_evt_ff;

endmodule : power_mode_controller

// File: pmc_props.sv
`timescale 1ns/100ps
module pmc_props (
   input wire logic                         i_sys_clk,
   input wire logic                         i_sys_rst,
   input wire logic                         i_mode_wr,
   input wire pmc_pkg::power_mode_e         i_mode_sel,
   input wire logic [pmc_pkg::WAKE_W-1:0]   i_wake,
   input wire logic [pmc_pkg::SUBSYS_W-1:0] o_subsys_en,
   input wire pmc_pkg::power_mode_e         o_mode,
   input wire pmc_pkg::regulator_ctl_s      o_reg_ctl,
   input wire pmc_pkg::clock_ctl_s          o_clk_ctl,
   input wire logic                         o_resuming,
   input wire logic                         o_wake_evt
);
   logic [15:0] res_cnt_ff;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // resume lengths exceed any delay range the tools unroll
   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
      if (i_sys_rst) res_cnt_ff <= 16'h0000;
      else res_cnt_ff <= o_resuming ? res_cnt_ff + 16'h0001 : 16'h0000;
   a_reset_mode_active: assert property (disable iff (1'b0)
      i_sys_rst |=> o_mode == pmc_pkg::MODE_ACTIVE && o_subsys_en == 8'hFF)
      else $error("not active after reset");
   a_sleep_all_off: assert property (o_mode == pmc_pkg::MODE_SLEEP |->
      o_subsys_en == pmc_pkg::SLEEP_KEEP_MASK) else $error("sleep subsystem on");
   a_sleep_keeps_timers: assert property (o_mode == pmc_pkg::MODE_SLEEP && !o_resuming |->
      o_clk_ctl.sleep_timer_on && o_clk_ctl.rtc_on) else $error("sleep timers off");
   a_hib_clocks_stop: assert property (o_mode == pmc_pkg::MODE_HIBERNATE && !o_resuming |->
      o_clk_ctl == 5'h01) else $error("hibernate clocks wrong");
   a_hib_only_hibreg: assert property (o_mode == pmc_pkg::MODE_HIBERNATE && !o_resuming |->
      o_reg_ctl == 6'h01) else $error("hibernate regulators wrong");
   a_hib_pin_wake: assert property (o_wake_evt && o_mode == pmc_pkg::MODE_HIBERNATE |->
      $past(i_wake[pmc_pkg::WAKE_PIN_BIT], 2)) else $error("hibernate woke without pin");
   a_wake_to_active: assert property (o_wake_evt |->
      o_mode == pmc_pkg::MODE_ACTIVE || o_resuming) else $error("wake not to active");
   a_resume_core_on: assert property ($fell(o_resuming) |->
      o_mode == pmc_pkg::MODE_ACTIVE && o_subsys_en[pmc_pkg::CORE_BIT])
      else $error("resume end wrong");
   a_sleep_resume_time: assert property (o_resuming && o_mode == pmc_pkg::MODE_SLEEP |->
      res_cnt_ff < 16'h0BB9) else $error("sleep resume too long");
   a_hib_resume_time: assert property (o_resuming && o_mode == pmc_pkg::MODE_HIBERNATE |->
      res_cnt_ff < 16'h4E21) else $error("hibernate resume too long");
   a_entry_by_write: assert property (o_mode != $past(o_mode) && o_mode != pmc_pkg::MODE_ACTIVE |->
      $past(i_mode_wr) && o_mode == $past(i_mode_sel)) else $error("mode entered without write");
endmodule : pmc_props
bind power_mode_controller pmc_props i_pmc_props (.i_sys_clk, .i_sys_rst, .i_mode_wr,
   .i_mode_sel, .i_wake, .o_subsys_en, .o_mode, .o_reg_ctl, .o_clk_ctl, .o_resuming, .o_wake_evt);

// File: pmc_wake_src.sv
`timescale 1ns/100ps
// a fired source holds its level until the wake is taken or cleared
module pmc_wake_src (
   input  wire logic       i_sys_clk,
   input  wire logic       i_fire,
   input  wire logic [5:0] i_mask,
   input  wire logic       i_clr,
   input  wire logic       i_taken,
   output logic      [5:0] o_wake
);
   initial o_wake = 6'h00;
   always @(posedge i_sys_clk)
      if (i_clr || i_taken) o_wake <= 6'h00;
      else if (i_fire) o_wake <= o_wake | i_mask;
endmodule : pmc_wake_src

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic                    i_sys_clk = 1'b0, i_sys_rst = 1'b1, mwr = 1'b0, ext = 1'b0;
   logic                    fire = 1'b0, clr = 1'b0, res, wake_evt, got_evt;
   logic [7:0]              act = 8'hFF, alt = 8'hFF, subsys;
   logic [5:0]              wake, wake_en = 6'h3F, mask = 6'h00;
   logic [31:0]             r;
   pmc_pkg::power_mode_e    sel = pmc_pkg::MODE_ACTIVE, mode;
   pmc_pkg::regulator_ctl_s rc;
   pmc_pkg::clock_ctl_s     cc;
   int                      err_count = 0, check_count = 0, n;
   always #2.5 i_sys_clk = ~i_sys_clk;
   power_mode_controller i_power_mode_controller (.i_sys_clk, .i_sys_rst, .i_mode_wr(mwr),
      .i_mode_sel(sel), .i_act_tmpl(act), .i_alt_tmpl(alt), .i_ext_reg(ext), .i_wake(wake),
      .i_wake_en(wake_en), .o_subsys_en(subsys), .o_mode(mode), .o_reg_ctl(rc),
      .o_clk_ctl(cc), .o_resuming(res), .o_wake_evt(wake_evt));
   pmc_wake_src i_pmc_wake_src (.i_sys_clk, .i_fire(fire), .i_mask(mask), .i_clr(clr),
      .i_taken(wake_evt), .o_wake(wake));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input pmc_pkg::power_mode_e m, input logic [7:0] a, input logic [7:0] b);
      @(posedge i_sys_clk);
      mwr <= 1'b1;
      sel <= m;
      act <= a;
      alt <= b;
      @(posedge i_sys_clk);
      mwr <= 1'b0;
      @(posedge i_sys_clk);
      #1;
   endtask : wr
   task automatic pulse(input logic [5:0] m, input logic c);
      @(posedge i_sys_clk);
      fire <= !c;
      clr <= c;
      mask <= m;
      @(posedge i_sys_clk);
      fire <= 1'b0;
      clr <= 1'b0;
   endtask : pulse
   // bound covers the two sync flops plus output register slack
   task automatic wake_up(input logic [5:0] m, input int lim);
      pulse(m, 1'b0);
      #1;
      n = 0;
      got_evt = 1'b0;
      // outputs read 1 ns past the edge, once they have settled
      while (!(mode === pmc_pkg::MODE_ACTIVE && res === 1'b0) && n < lim) begin
         @(posedge i_sys_clk);
         #1;
         if (wake_evt === 1'b1) got_evt = 1'b1;
         n++;
      end
      check(8'(got_evt), 8'h01);
      if (n >= lim) begin
         err_count++;
         tally_and_finish();
      end
   endtask : wake_up
   initial begin
      void'($urandom(32'h1DB7));
      repeat (16) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      #1;
      check(8'(mode), 8'(pmc_pkg::MODE_ACTIVE));
      check(subsys, 8'hFF);
      check(8'(rc), 8'h33);
      check(8'(cc), 8'h1F);
      $display("end reset");
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         wr(pmc_pkg::MODE_ACTIVE, r[7:0], r[15:8]);
         check(subsys, r[7:0]);
      end
      wr(pmc_pkg::MODE_ALT_ACTIVE, act, {r[15:9], 1'b0});
      check(8'(mode), 8'(pmc_pkg::MODE_ALT_ACTIVE));
      check(subsys, alt);
      wake_up(6'h01 << (1 + $urandom % 5), 8);
      check(subsys, act | 8'h01);
      @(posedge i_sys_clk);
      ext <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      #1;
      check(8'(rc[5:4]), 8'h00);
      @(posedge i_sys_clk);
      ext <= 1'b0;
      $display("end active");
      wr(pmc_pkg::MODE_SLEEP, act, alt);
      check(subsys, 8'h00);
      check(8'(rc[3:2]), 8'h03);
      check(8'(cc[2:1]), 8'h03);
      wake_up(6'h01 << (1 + $urandom % 5), pmc_pkg::SLEEP_RESUME_CYC + 6);
      check(subsys, act | 8'h01);
      $display("end sleep");
      wr(pmc_pkg::MODE_HIBERNATE, act, alt);
      check(8'(rc), 8'h01);
      check(8'(cc), 8'h01);
      pulse(6'h3E, 1'b0);
      repeat (50) @(posedge i_sys_clk);
      check(8'(mode), 8'(pmc_pkg::MODE_HIBERNATE));
      pulse(6'h00, 1'b1);
      wake_up(6'h01, pmc_pkg::HIB_RESUME_CYC + 6);
      check(subsys, act | 8'h01);
      $display("end hibernate");
      tally_and_finish();
   end
endmodule : tb_top
